/* common/ssp_cfg.svh */
// constants for the software stack pointer block
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_RESET_SP      16'h0800
`define SSP_UNDERFLOW_LIM 16'h0800
`define SSP_WORD_STEP     16'h0002
`define SSP_PC_MSB        23
`endif

/* common/ssp_pkg.sv */
// types for the software stack pointer block
`default_nettype none
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_OP_NONE  = 3'b000,
        SSP_OP_PUSH  = 3'b001,
        SSP_OP_POP   = 3'b010,
        SSP_OP_CALL  = 3'b011,
        SSP_OP_EXC   = 3'b100,
        SSP_OP_WRITE = 3'b101
    } ssp_op_t;
endpackage : ssp_pkg
`default_nettype wire

/* src/ssp_limit_check.sv */
// stack limit register and stack error check
`timescale 1ns/10ps
`default_nettype none
`include "ssp_cfg.svh"
module ssp_limit_check (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        limWrite,
    input  wire logic [15:0] limData,
    input  wire logic        pushReq,
    input  wire logic        spAccess,
    input  wire logic [15:0] spValue,
    input  wire logic [15:0] effAddr,
    output logic             overflowErr,
    output logic             underflowErr,
    output logic [15:0]      stackLimit
);
    // limit has no reset value: software must load it before relying on it
    always_ff @(posedge core_clk) begin
        if (limWrite) begin
            stackLimit <= {limData[15:1], 1'b0};
        end
    end

    // push at pointer equal to limit is allowed; one beyond traps
    assign overflowErr  = spAccess && pushReq && (effAddr > stackLimit);
    assign underflowErr = spAccess && (spValue < `SSP_UNDERFLOW_LIM);

    AST_LIM_LOAD: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $past(limWrite) |-> stackLimit == {$past(limData[15:1]), 1'b0})
        else $error("limit load lost");
endmodule : ssp_limit_check
`default_nettype wire

/* src/ssp_stack_pointer.sv */
// software stack pointer working register with push, pop and traps
//
// Summary of operation
// - working register also serves as stack pointer
// - pointer addresses next free word, grows upward
// - push writes then increments; pop decrements then reads
// - call pushes program counter with top bit clear
// - push beyond stack limit raises stack error
// - push or pop access at an address below 0x0800 raises underflow error
// - exception push puts status low byte on top
// - limit register unreset, bit 0 forced zero
`timescale 1ns/10ps
`default_nettype none
`include "ssp_cfg.svh"
module ssp_stack_pointer #(
    parameter int PC_W = 24
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire ssp_pkg::ssp_op_t opCode,
    input  wire logic [15:0]      regWriteData,
    input  wire logic [15:0]      pushData,
    input  wire logic [PC_W-1:0]  programCounter,
    input  wire logic [7:0]       statusLowByte,
    input  wire logic             limWrite,
    input  wire logic [15:0]      limData,
    input  wire logic [15:0]      memReadData,
    output logic [15:0]           stackPointer,
    output logic [15:0]           memAddr,
    output logic [15:0]           memWriteData,
    output logic                  memWrite,
    output logic                  memRead,
    output logic [15:0]           popData,
    output logic                  popValid,
    output logic                  stackErrTrap,
    output logic                  underflowTrap
);
    import ssp_pkg::*;

    typedef enum logic [1:0] {
        SSP_IDLE  = 2'b00,
        SSP_HIGH  = 2'b01,
        SSP_RDWT  = 2'b10
    } ssp_state_t;

    ssp_state_t  state;
    logic [15:0] pcHighWord;
    logic [15:0] next_sp;
    logic        pushing;
    logic        spAccess;
    logic        ovf;
    logic        unf;
    logic [15:0] stackLimit;
    logic [15:0] effAddr;

    // two-word frame: low pc word first, then high word
    always_comb begin
        pcHighWord = {{(16 - (PC_W - 16)){1'b0}}, programCounter[PC_W-1:16]};
        if (opCode == SSP_OP_EXC) begin
            pcHighWord = {statusLowByte, pcHighWord[7:0]};
        end
        pcHighWord[15] = (opCode == SSP_OP_EXC) ? statusLowByte[7] : 1'b0;
        if (opCode != SSP_OP_EXC) begin
            pcHighWord[PC_W-17] = 1'b0;
        end
    end

    assign pushing  = (state == SSP_IDLE) &&
                      (opCode == SSP_OP_PUSH || opCode == SSP_OP_CALL ||
                       opCode == SSP_OP_EXC) || (state == SSP_HIGH);
    assign spAccess = pushing ||
                      ((state == SSP_IDLE) && (opCode == SSP_OP_POP));
    assign effAddr  = pushing ? stackPointer
                              : stackPointer - `SSP_WORD_STEP;

    ssp_limit_check u_limit (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .limWrite     (limWrite),
        .limData      (limData),
        .pushReq      (pushing),
        .spAccess     (spAccess),
        .spValue      (effAddr),
        .effAddr      (effAddr),
        .overflowErr  (ovf),
        .underflowErr (unf),
        .stackLimit   (stackLimit)
    );

    always_comb begin
        next_sp = stackPointer;
        if (state == SSP_IDLE && opCode == SSP_OP_WRITE) begin
            next_sp = {regWriteData[15:1], 1'b0};
        end else if (pushing) begin
            next_sp = stackPointer + `SSP_WORD_STEP;
        end else if (state == SSP_IDLE && opCode == SSP_OP_POP) begin
            next_sp = stackPointer - `SSP_WORD_STEP;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stackPointer <= `SSP_RESET_SP;
        end else begin
            stackPointer <= next_sp;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SSP_IDLE;
        end else begin
            case (state)
                SSP_IDLE: begin
                    if (opCode == SSP_OP_CALL || opCode == SSP_OP_EXC) begin
                        state <= SSP_HIGH;
                    end else if (opCode == SSP_OP_POP) begin
                        state <= SSP_RDWT;
                    end
                end
                default: state <= SSP_IDLE;
            endcase
        end
    end

    logic [15:0] heldHigh;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            heldHigh <= 16'h0000;
        end else if (state == SSP_IDLE) begin
            heldHigh <= pcHighWord;
        end
    end

    // memory side: write at old pointer, read at decremented pointer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            memAddr      <= 16'h0000;
            memWriteData <= 16'h0000;
            memWrite     <= 1'b0;
            memRead      <= 1'b0;
        end else begin
            memAddr  <= effAddr;
            memWrite <= pushing;
            memRead  <= (state == SSP_IDLE) && (opCode == SSP_OP_POP);
            if (state == SSP_HIGH) begin
                memWriteData <= heldHigh;
            end else if (opCode == SSP_OP_PUSH) begin
                memWriteData <= pushData;
            end else begin
                memWriteData <= programCounter[15:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            popData  <= 16'h0000;
            popValid <= 1'b0;
        end else begin
            popValid <= (state == SSP_RDWT);
            if (state == SSP_RDWT) begin
                popData <= memReadData;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stackErrTrap  <= 1'b0;
            underflowTrap <= 1'b0;
        end else begin
            stackErrTrap  <= ovf;
            underflowTrap <= unf;
        end
    end

    AST_SP_ALIGNED: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        stackPointer[0] == 1'b0) else $error("pointer misaligned");
    AST_PUSH_INC: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (state == SSP_IDLE && opCode == SSP_OP_PUSH) |=>
        stackPointer == $past(stackPointer) + 16'h0002 &&
        memWrite && memAddr == $past(stackPointer))
        else $error("push did not post-increment");
    AST_POP_DEC: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (state == SSP_IDLE && opCode == SSP_OP_POP) |=>
        memRead && memAddr == stackPointer &&
        stackPointer == $past(stackPointer) - 16'h0002)
        else $error("pop did not pre-decrement");
    // the pc top bit lands in bit PC_W-17 of the high word
    AST_CALL_MSB: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (state == SSP_IDLE && opCode == SSP_OP_CALL) |=> ##1
        memWrite && memWriteData[15] == 1'b0 &&
        memWriteData[PC_W-17] == 1'b0)
        else $error("call pushed set top bit");
    AST_EXC_SRL: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (state == SSP_IDLE && opCode == SSP_OP_EXC) |=> ##1
        memWriteData[15:8] == $past(statusLowByte, 2))
        else $error("exception frame lacks status");
    AST_UNDERFLOW: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (spAccess && effAddr < 16'h0800) |=> underflowTrap)
        else $error("underflow not trapped");
    AST_LIMIT_EQ: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pushing && effAddr == stackLimit) |=> !stackErrTrap)
        else $error("trap at equal limit");
    AST_LIMIT_OVER: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (pushing && effAddr > stackLimit) |=> stackErrTrap)
        else $error("push beyond limit not trapped");
    AST_WRITE_REG: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (state == SSP_IDLE && opCode == SSP_OP_WRITE) |=>
        stackPointer == {$past(regWriteData[15:1]), 1'b0})
        else $error("register write lost");
    AST_LIM_BIT0: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $past(limWrite) |-> stackLimit[0] == 1'b0)
        else $error("limit bit 0 set");
endmodule : ssp_stack_pointer
`default_nettype wire

/* verif/ssp_mem_model.sv */
// data memory model on the far side of the stack block
`timescale 1ns/10ps
`default_nettype none
module ssp_mem_model (
    input  wire logic        core_clk,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWriteData,
    input  wire logic        memWrite,
    input  wire logic        memRead,
    output logic [15:0]      memReadData
);
    logic [15:0] mem [0:32767];
    logic [15:0] lastData = 16'h0000;
    always @(posedge core_clk) begin
        if (memWrite === 1'b1) begin
            mem[memAddr[15:1]] <= memWriteData;
        end
        if (memRead === 1'b1) begin
            lastData <= mem[memAddr[15:1]];
        end
    end
    // idle read bus shows the inverse so a stale value cannot pass
    assign memReadData = memRead ? mem[memAddr[15:1]] : ~lastData;
endmodule : ssp_mem_model
`default_nettype wire

/* verif/tb_software_stack_pointer.sv */
// self-checking bench for the software stack pointer
`timescale 1ns/10ps
`default_nettype none
`define SSP_CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) \
    begin errors++; $display("CHECK FAILED %0t %s", $time, msg); end end
module tb_software_stack_pointer;
    import ssp_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    ssp_op_t     opCode = SSP_OP_NONE;
    logic [15:0] regWriteData = 16'h0000;
    logic [15:0] pushData = 16'h0000;
    logic [23:0] programCounter = 24'h000000;
    logic [7:0]  statusLowByte = 8'h00;
    logic        limWrite = 1'b0;
    logic [15:0] limData = 16'h0000;
    logic [15:0] memReadData, stackPointer, memAddr, memWriteData, popData;
    logic        memWrite, memRead, popValid, stackErrTrap, underflowTrap;
    int          errors = 0;
    int          total_checks = 0;
    int          errCnt = 0;
    int          undCnt = 0;
    logic [31:0] seed = 32'h0cc38d68;
    logic [15:0] expSp = 16'h0800;
    logic [31:0] wrQ [$];
    logic [15:0] popQ [$];
    logic [15:0] shadow [logic [15:0]];
    logic [31:0] exp32;
    ssp_stack_pointer #(.PC_W(24)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .opCode(opCode),
        .regWriteData(regWriteData), .pushData(pushData),
        .programCounter(programCounter), .statusLowByte(statusLowByte),
        .limWrite(limWrite), .limData(limData), .memReadData(memReadData),
        .stackPointer(stackPointer), .memAddr(memAddr),
        .memWriteData(memWriteData), .memWrite(memWrite),
        .memRead(memRead), .popData(popData), .popValid(popValid),
        .stackErrTrap(stackErrTrap), .underflowTrap(underflowTrap));
    ssp_mem_model u_mem (
        .core_clk(core_clk), .memAddr(memAddr), .memWriteData(memWriteData),
        .memWrite(memWrite), .memRead(memRead), .memReadData(memReadData));
    always #5 core_clk = ~core_clk;
    task automatic note(input logic [15:0] a, input logic [15:0] d);
        wrQ.push_back({a, d});
        shadow[a] = d;
    endtask : note
    task automatic send(input ssp_op_t op, input logic [15:0] v);
        logic [15:0] hi;
        hi = {9'h000, programCounter[22:16]};
        @(negedge core_clk);
        opCode = op;
        regWriteData = v;
        pushData = v;
        case (op)
            SSP_OP_PUSH: begin
                note(expSp, v);
                expSp += 16'h0002;
            end
            SSP_OP_WRITE: expSp = v & 16'hfffe;
            SSP_OP_POP: begin
                expSp -= 16'h0002;
                popQ.push_back(shadow[expSp]);
            end
            default: begin
                // only calls clear the pc top bit; exceptions keep it
                if (op == SSP_OP_EXC) hi[15:7] = {statusLowByte,
                                                  programCounter[23]};
                note(expSp, programCounter[15:0]);
                note(expSp + 16'h0002, hi);
                expSp += 16'h0004;
            end
        endcase
        // the cycle after a two-cycle op is refused, so hold none there
        if (op inside {SSP_OP_POP, SSP_OP_CALL, SSP_OP_EXC}) begin
            @(negedge core_clk);
            opCode = SSP_OP_NONE;
        end
        @(negedge core_clk);
        opCode = SSP_OP_NONE;
    endtask : send
    task automatic loadLim(input logic [15:0] v);
        @(negedge core_clk);
        limWrite = 1'b1;
        limData = v;
        @(negedge core_clk);
        limWrite = 1'b0;
    endtask : loadLim
    always @(posedge core_clk) begin
        if (rst_n && memWrite === 1'b1) begin
            exp32 = wrQ.size() ? wrQ.pop_front() : 32'hxxxxxxxx;
            `SSP_CHK({memAddr, memWriteData}, exp32, "write")
        end
        if (rst_n && popValid === 1'b1) begin
            `SSP_CHK(popData, popQ.pop_front(), "pop data")
        end
        if (stackErrTrap === 1'b1) errCnt++;
        if (underflowTrap === 1'b1) undCnt++;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        `SSP_CHK({stackPointer, memWrite}, 17'h01000, "reset")
        @(negedge core_clk);
        rst_n = 1'b1;
        $display("test reset done");
        loadLim(16'h0803);
        repeat (3) send(SSP_OP_PUSH, 16'($random(seed)));
        // the trap pulse reaches the counter one edge later
        @(negedge core_clk);
        `SSP_CHK(errCnt, 1, "limit trap")
        `SSP_CHK(stackPointer, expSp, "push pointer")
        $display("test push limit done");
        loadLim(16'hfffe);
        send(SSP_OP_WRITE, 16'h1001);
        `SSP_CHK(stackPointer, expSp, "write align")
        programCounter = {1'b1, 23'($random(seed))};
        send(SSP_OP_CALL, 16'h0000);
        programCounter = {1'b1, 23'($random(seed))};
        statusLowByte = 8'($random(seed));
        send(SSP_OP_EXC, 16'h0000);
        repeat (2) send(SSP_OP_POP, 16'h0000);
        `SSP_CHK(stackPointer, expSp, "frame pointer")
        $display("test call frame done");
        send(SSP_OP_WRITE, 16'h07fe);
        send(SSP_OP_PUSH, 16'($random(seed)));
        send(SSP_OP_POP, 16'h0000);
        // let the monitor take the last pop result off its queue
        @(negedge core_clk);
        `SSP_CHK(undCnt, 2, "underflow trap")
        `SSP_CHK(errCnt, 1, "no extra limit trap")
        `SSP_CHK(wrQ.size() + popQ.size(), 0, "all results seen")
        $display("test underflow done");
        @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        `SSP_CHK({stackPointer, memWrite, popValid}, 18'h02000, "mid reset")
        rst_n = 1'b1;
        expSp = 16'h0800;
        send(SSP_OP_PUSH, 16'($random(seed)));
        send(SSP_OP_POP, 16'h0000);
        @(negedge core_clk);
        `SSP_CHK(stackPointer, expSp, "after reset")
        `SSP_CHK(wrQ.size() + popQ.size(), 0, "reset results")
        $display("test mid reset done");
        end_sim();
    end
endmodule : tb_software_stack_pointer
`default_nettype wire
